//--- pmcs_ctrl.sv
// pmcs_ctrl: power-managed mode and clock switch controller
// assumes all inputs except ARST_N synchronous to SYS_CLK, one-cycle instruction pulses
//
// Operation
// RULE1: idle, select 00: CPU stops, peripherals primary
// RULE2: primary idle keeps primary flag set
// RULE3: primary idle wake: CPU after 10 us
// RULE4: idle 01: peripherals secondary, primary off
// RULE5: secondary disabled: forced no-op, no entry
// RULE6: secondary not oscillating: hold its clocks
// RULE7: secondary idle wake: run secondary, 10 us
// RULE8: wake keeps select bits, secondary running
// RULE9: idle 1x: peripherals internal mux, primary off
// RULE10: nonzero frequency: fast osc, stable after 1ms
// RULE11: stable flag kept; zero field keeps off
// RULE12: internal idle wake: 10 us, then primary
// RULE13: slow osc kept with watchdog or monitor
// RULE14: no idle select: CPU and peripherals switched
// RULE15: watchdog in run mode gives reset
// RULE16: run mode left on interrupt, reset, sleep
// RULE17: primary run default; others return there
// RULE18: primary run: primary flag, fast optional
// RULE19: run 01: system on secondary, flags
// RULE20: secondary run wake: switch when primary ready
// RULE21: secondary enable cleared forces exit
// RULE22: all select bits zero: full sleep
// RULE23: mode sampled at each sleep instruction
// RULE24: delays as counters, primary ready input
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module pmcs_ctrl #(
  parameter int WAKE_CYC = pmcs_pkg::WAKE_CYC,
  parameter int STAB_CYC = pmcs_pkg::STAB_CYC
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLEEP_EXEC,
  input wire logic RESET_INSTR,
  input wire logic WAKE_EVENT,
  input wire logic WDT_TIMEOUT,
  input wire logic PRIMARY_READY,
  input wire logic SEC_OSC_RUNNING,
  input wire logic PRIMARY_IS_FAST_INTERNAL_OSCILLATOR,
  input wire logic WDT_ENABLE,
  input wire logic FSCM_ENABLE,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic [1:0] CLK_SEL,
  output logic PRIMARY_OSC_EN,
  output logic SEC_OSC_EN,
  output logic FAST_OSC_EN,
  output logic SLOW_OSC_EN,
  output logic WDT_RESET,
  output logic FORCED_NOP
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (WAKE_CYC < 4 || STAB_CYC < 1) begin : g_bad_param
    $error("pmcs_ctrl: wake count below four or stable count zero");
  end

  localparam int WCW = $clog2(WAKE_CYC + 1);
  localparam int SCW = $clog2(STAB_CYC + 1);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pmcs_pkg::pmcs_mode_t mode;
    logic [WCW-1:0] wake_cnt;
    logic waking;
    logic exit_pend;
    logic [SCW-1:0] stab_cnt;
    logic osc_stable;
    logic idle_sel;
    logic [2:0] freq;
    logic [1:0] css;
    logic sec_en;
    logic pri_flag;
    logic fast_flag;
    logic sec_flag;
    logic wdt_rst;
    logic nop;
  } pmcs_st_t;

  localparam pmcs_st_t RST_ST = '{
    mode: pmcs_pkg::primary_run_state,
    wake_cnt: '0,
    waking: 1'b0,
    exit_pend: 1'b0,
    stab_cnt: '0,
    osc_stable: 1'b0,
    idle_sel: pmcs_pkg::RST_IDLE_SEL,
    freq: pmcs_pkg::RST_FREQ,
    css: pmcs_pkg::RST_CSS,
    sec_en: pmcs_pkg::RST_SEC_EN,
    pri_flag: pmcs_pkg::RST_PRI_FLAG,
    fast_flag: 1'b0,
    sec_flag: 1'b0,
    wdt_rst: 1'b0,
    nop: 1'b0
  };

  pmcs_st_t st_q;
  pmcs_st_t st_d;
  logic wr_en;
  logic is_run_lp;
  logic is_idle;
  logic sec_sel;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign is_run_lp = st_q.mode == pmcs_pkg::secondary_run_state ||
                     st_q.mode == pmcs_pkg::internal_osc_run_state;
  assign is_idle = st_q.mode == pmcs_pkg::primary_idle_state ||
                   st_q.mode == pmcs_pkg::secondary_idle_state ||
                   st_q.mode == pmcs_pkg::internal_osc_idle_state;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.wdt_rst = 1'b0;
    st_d.nop = 1'b0;
    // RULE10: fast osc stabilisation count
    if (st_q.freq == 3'h0 || st_q.mode == pmcs_pkg::sleep_state) begin
      // RULE11: zero field keeps it off
      st_d.stab_cnt = '0;
      st_d.osc_stable = 1'b0;
    end else if (!st_q.osc_stable) begin
      if (st_q.stab_cnt == SCW'(STAB_CYC - 1)) begin
        st_d.osc_stable = 1'b1;
      end else begin
        st_d.stab_cnt = st_q.stab_cnt + 1'b1;
      end
    end
    if (st_q.wake_cnt != '0) begin
      st_d.wake_cnt = st_q.wake_cnt - 1'b1;
    end
    unique case (st_q.mode)
      pmcs_pkg::primary_run_state,
      pmcs_pkg::secondary_run_state,
      pmcs_pkg::internal_osc_run_state: begin
        if (is_run_lp && WDT_TIMEOUT) begin
          // RULE15: watchdog gives reset in run
          st_d.wdt_rst = 1'b1;
        end else if (SLEEP_EXEC) begin
          // RULE23: decode select bits now
          st_d.exit_pend = 1'b0;
          if (st_q.css == pmcs_pkg::CSS_PRIMARY) begin
            if (st_q.idle_sel) begin
              // RULE1: primary idle entry
              st_d.mode = pmcs_pkg::primary_idle_state;
              // RULE2: primary flag held
              st_d.pri_flag = 1'b1;
              st_d.sec_flag = 1'b0;
            end else begin
              // RULE22: full sleep, all flags clear
              st_d.mode = pmcs_pkg::sleep_state;
              st_d.pri_flag = 1'b0;
              st_d.sec_flag = 1'b0;
            end
          end else if (st_q.css == pmcs_pkg::CSS_SECONDARY) begin
            if (!st_q.sec_en) begin
              // RULE5: forced no-op, mode kept
              st_d.nop = 1'b1;
            end else begin
              // RULE4: secondary idle, RULE19: secondary run
              st_d.mode = st_q.idle_sel ?
                          pmcs_pkg::secondary_idle_state :
                          pmcs_pkg::secondary_run_state;
              st_d.pri_flag = 1'b0;
              st_d.sec_flag = 1'b1;
            end
          end else begin
            // RULE9: internal mux modes, RULE14: run variant
            st_d.mode = st_q.idle_sel ?
                        pmcs_pkg::internal_osc_idle_state :
                        pmcs_pkg::internal_osc_run_state;
            st_d.pri_flag = 1'b0;
            st_d.sec_flag = 1'b0;
          end
        end else begin
          // RULE16: interrupt leaves run mode
          if (is_run_lp && WAKE_EVENT) begin
            st_d.exit_pend = 1'b1;
          end
          // RULE21: cleared enable forces exit
          if (st_q.mode == pmcs_pkg::secondary_run_state &&
              !st_q.sec_en) begin
            st_d.exit_pend = 1'b1;
          end
          // RULE20: switch once primary ready
          if (is_run_lp && st_q.exit_pend && PRIMARY_READY &&
              st_q.wake_cnt == '0) begin
            st_d.mode = pmcs_pkg::primary_run_state;
            st_d.exit_pend = 1'b0;
            st_d.pri_flag = 1'b1;
            st_d.sec_flag = 1'b0;
          end
        end
      end
      pmcs_pkg::primary_idle_state,
      pmcs_pkg::secondary_idle_state,
      pmcs_pkg::internal_osc_idle_state: begin
        if (!st_q.waking && (WAKE_EVENT || WDT_TIMEOUT)) begin
          // RULE3: CPU ready delay count
          st_d.waking = 1'b1;
          st_d.wake_cnt = WCW'(WAKE_CYC - 1);
          st_d.exit_pend =
            st_q.mode != pmcs_pkg::primary_idle_state;
        end else if (st_q.waking && st_q.wake_cnt == '0) begin
          st_d.waking = 1'b0;
          // RULE7: secondary run, RULE12: internal run
          unique case (st_q.mode)
            pmcs_pkg::secondary_idle_state:
              st_d.mode = pmcs_pkg::secondary_run_state;
            pmcs_pkg::internal_osc_idle_state:
              st_d.mode = pmcs_pkg::internal_osc_run_state;
            default:
              st_d.mode = pmcs_pkg::primary_run_state;
          endcase
        end
      end
      pmcs_pkg::sleep_state: begin
        if (WAKE_EVENT || WDT_TIMEOUT) begin
          st_d.exit_pend = 1'b1;
        end
        // RULE17: return to primary run
        if (st_q.exit_pend && PRIMARY_READY) begin
          st_d.mode = pmcs_pkg::primary_run_state;
          st_d.exit_pend = 1'b0;
          st_d.pri_flag = 1'b1;
        end
      end
      default: st_d.mode = pmcs_pkg::primary_run_state;
    endcase
    // RULE18: fast flag on fast_internal_oscillator primary, RULE12: cleared
    st_d.fast_flag = st_d.osc_stable &&
      (st_d.mode == pmcs_pkg::internal_osc_run_state ||
       st_d.mode == pmcs_pkg::internal_osc_idle_state ||
       (PRIMARY_IS_FAST_INTERNAL_OSCILLATOR &&
        (st_d.mode == pmcs_pkg::primary_run_state ||
         st_d.mode == pmcs_pkg::primary_idle_state)));
    // RULE8: wake logic never touches select bits
    if (wr_en && PADDR == pmcs_pkg::OFS_OSC_CTRL) begin
      st_d.idle_sel = PWDATA[pmcs_pkg::POS_IDLE_SEL];
      st_d.freq = PWDATA[pmcs_pkg::POS_FREQ_LO +: 3];
      st_d.css = PWDATA[pmcs_pkg::POS_CSS_LO +: 2];
    end
    if (wr_en && PADDR == pmcs_pkg::OFS_SEC_CTRL) begin
      st_d.sec_en = PWDATA[pmcs_pkg::POS_SEC_EN];
    end
    // RULE16: reset instruction leaves any mode
    if (RESET_INSTR) begin
      st_d = RST_ST;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= RST_ST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // clock gating and oscillator control
  // ****************************************
  always_comb begin
    unique case (st_q.mode)
      pmcs_pkg::secondary_run_state,
      pmcs_pkg::secondary_idle_state: CLK_SEL = pmcs_pkg::CSS_SECONDARY;
      pmcs_pkg::internal_osc_run_state,
      pmcs_pkg::internal_osc_idle_state: CLK_SEL = pmcs_pkg::SEL_INTMUX;
      default: CLK_SEL = pmcs_pkg::CSS_PRIMARY;
    endcase
  end

  assign sec_sel = CLK_SEL == pmcs_pkg::CSS_SECONDARY;
  // RULE6: secondary clocks held until oscillating
  assign PERIPH_CLK_EN = st_q.mode != pmcs_pkg::sleep_state &&
                         (!sec_sel || SEC_OSC_RUNNING);
  // RULE1: CPU stopped in idle and during delay
  assign CPU_CLK_EN = PERIPH_CLK_EN && !is_idle;
  // RULE24: primary started on pending exit
  assign PRIMARY_OSC_EN = st_q.mode == pmcs_pkg::primary_run_state ||
                          st_q.mode == pmcs_pkg::primary_idle_state ||
                          st_q.exit_pend;
  // RULE21: secondary kept while still clocking
  assign SEC_OSC_EN = st_q.sec_en || sec_sel;
  assign FAST_OSC_EN = st_q.freq != 3'h0 &&
                       st_q.mode != pmcs_pkg::sleep_state;
  // RULE13: slow osc for watchdog or monitor
  assign SLOW_OSC_EN = WDT_ENABLE || FSCM_ENABLE ||
                       (CLK_SEL == pmcs_pkg::SEL_INTMUX &&
                        st_q.freq == 3'h0);
  assign WDT_RESET = st_q.wdt_rst;
  assign FORCED_NOP = st_q.nop;

  // ****************************************
  // apb slave
  // ****************************************
  assign PREADY = 1'b1;
  always_comb begin
    PRDATA = 32'h0000_0000;
    PSLVERR = 1'b0;
    unique case (PADDR)
      pmcs_pkg::OFS_OSC_CTRL: begin
        PRDATA[pmcs_pkg::POS_IDLE_SEL] = st_q.idle_sel;
        PRDATA[pmcs_pkg::POS_FREQ_LO +: 3] = st_q.freq;
        PRDATA[pmcs_pkg::POS_PRI_FLAG] = st_q.pri_flag;
        PRDATA[pmcs_pkg::POS_FAST_FLAG] = st_q.fast_flag;
        PRDATA[pmcs_pkg::POS_CSS_LO +: 2] = st_q.css;
      end
      pmcs_pkg::OFS_SEC_CTRL: begin
        PRDATA[pmcs_pkg::POS_SEC_FLAG] = st_q.sec_flag;
        PRDATA[pmcs_pkg::POS_SEC_EN] = st_q.sec_en;
      end
      pmcs_pkg::OFS_MODE_STAT: PRDATA[2:0] = st_q.mode;
      default: PSLVERR = PSEL && PENABLE;
    endcase
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  a_sleep_clocks_off: assert property ( // RULE22
    st_q.mode == pmcs_pkg::sleep_state |->
      !PERIPH_CLK_EN && !CPU_CLK_EN && !st_q.pri_flag)
    else $error("clocks running in sleep");

  a_primary_idle_state_flag: assert property ( // RULE2
    st_q.mode == pmcs_pkg::primary_idle_state |-> st_q.pri_flag)
    else $error("primary flag lost in primary idle");

  a_wake_cpu_held: assert property ( // RULE3
    is_idle && !st_q.waking && WAKE_EVENT && !RESET_INSTR |=>
      !CPU_CLK_EN [*4])
    else $error("cpu clocked before ready delay");

  a_nop_no_entry: assert property ( // RULE5
    st_q.nop |-> st_q.mode == $past(st_q.mode) && !sec_sel)
    else $error("secondary entered with oscillator off");

  a_sec_clk_hold: assert property ( // RULE6
    sec_sel && !SEC_OSC_RUNNING |-> !PERIPH_CLK_EN && !CPU_CLK_EN)
    else $error("secondary clock passed before start");

  a_wdt_run_reset: assert property ( // RULE15
    is_run_lp && WDT_TIMEOUT && !RESET_INSTR |=>
      WDT_RESET && $stable(st_q.mode))
    else $error("watchdog in run mode did not reset");

  a_switch_flags: assert property ( // RULE12
    $past(is_run_lp) && st_q.mode == pmcs_pkg::primary_run_state &&
      !$past(RESET_INSTR) |->
      st_q.pri_flag && !st_q.sec_flag && PRIMARY_OSC_EN)
    else $error("flags wrong after switch to primary");

  a_slow_osc_keep: assert property ( // RULE13
    WDT_ENABLE || FSCM_ENABLE |-> SLOW_OSC_EN)
    else $error("slow oscillator stopped");

  a_secondary_run_state_entry: assert property ( // RULE19
    st_q.mode == pmcs_pkg::primary_run_state && SLEEP_EXEC &&
      !st_q.idle_sel && st_q.css == pmcs_pkg::CSS_SECONDARY &&
      st_q.sec_en && !WDT_TIMEOUT && !RESET_INSTR && !wr_en |=>
      st_q.mode == pmcs_pkg::secondary_run_state &&
      st_q.sec_flag && !st_q.pri_flag && !PRIMARY_OSC_EN)
    else $error("secondary run entry wrong");

  c_primary_idle_state_wake: cover property (
    st_q.mode == pmcs_pkg::primary_idle_state ##1
      st_q.mode == pmcs_pkg::primary_run_state);
  c_sec_forced_exit: cover property (
    st_q.mode == pmcs_pkg::secondary_run_state && !st_q.sec_en ##1
      st_q.mode == pmcs_pkg::primary_run_state);
  c_rc_fast_stable: cover property (
    st_q.mode == pmcs_pkg::internal_osc_idle_state && st_q.fast_flag);

endmodule : pmcs_ctrl

//--- pmcs_ctrl_tb_top.sv
// pmcs_ctrl_tb_top: self-checking bench for the power mode clock switch
// assumes pmcs_ctrl with assertions inside, APB slave with zero waits
`timescale 1ns/1ps
module pmcs_ctrl_tb_top;
  // ****************************************
  // signals
  // ****************************************
  localparam int WAKE_N = 4;
  localparam int STAB_N = 8;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR;
  logic SLEEP_EXEC = 1'b0;
  logic RESET_INSTR = 1'b0;
  logic WAKE_EVENT = 1'b0;
  logic WDT_TIMEOUT = 1'b0;
  logic PRIMARY_READY = 1'b0;
  logic SEC_OSC_RUNNING = 1'b0;
  logic PRIMARY_IS_FAST_INTERNAL_OSCILLATOR = 1'b0;
  logic WDT_ENABLE = 1'b0;
  logic FSCM_ENABLE = 1'b1;
  logic CPU_CLK_EN, PERIPH_CLK_EN, PRIMARY_OSC_EN, SEC_OSC_EN;
  logic FAST_OSC_EN, SLOW_OSC_EN, WDT_RESET, FORCED_NOP;
  logic [1:0] CLK_SEL;
  int mismatches = 0;
  int compares = 0;

  always #4 SYS_CLK = ~SYS_CLK;

  pmcs_ctrl #(.WAKE_CYC(WAKE_N), .STAB_CYC(STAB_N)) i_pmcs_ctrl (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_EXEC(SLEEP_EXEC),
    .RESET_INSTR(RESET_INSTR), .WAKE_EVENT(WAKE_EVENT),
    .WDT_TIMEOUT(WDT_TIMEOUT), .PRIMARY_READY(PRIMARY_READY),
    .SEC_OSC_RUNNING(SEC_OSC_RUNNING),
    .PRIMARY_IS_FAST_INTERNAL_OSCILLATOR(PRIMARY_IS_FAST_INTERNAL_OSCILLATOR), .WDT_ENABLE(WDT_ENABLE),
    .FSCM_ENABLE(FSCM_ENABLE), .CPU_CLK_EN(CPU_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .CLK_SEL(CLK_SEL),
    .PRIMARY_OSC_EN(PRIMARY_OSC_EN), .SEC_OSC_EN(SEC_OSC_EN),
    .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN),
    .WDT_RESET(WDT_RESET), .FORCED_NOP(FORCED_NOP));

  // ****************************************
  // helpers
  // ****************************************
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(what, r, exp);
  endtask : rdc

  task pulse(input int which);
    @(posedge SYS_CLK);
    case (which)
      0: SLEEP_EXEC <= 1'b1;
      1: WAKE_EVENT <= 1'b1;
      3: RESET_INSTR <= 1'b1;
      default: WDT_TIMEOUT <= 1'b1;
    endcase
    @(posedge SYS_CLK);
    RESET_INSTR <= 1'b0;
    SLEEP_EXEC <= 1'b0;
    WAKE_EVENT <= 1'b0;
    WDT_TIMEOUT <= 1'b0;
  endtask : pulse

  // cpu, periph, sel, primary osc, secondary osc
  task outs(input logic [5:0] exp);
    @(negedge SYS_CLK);
    check("clocks", {CPU_CLK_EN, PERIPH_CLK_EN, CLK_SEL, PRIMARY_OSC_EN,
      SEC_OSC_EN}, {26'h000_0000, exp});
  endtask : outs

  task wait_mode(input logic [2:0] exp);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    apb(1'b0, pmcs_pkg::OFS_MODE_STAT, 32'h0000_0000, r, e);
    while (r[2:0] !== exp && n < 40) begin
      apb(1'b0, pmcs_pkg::OFS_MODE_STAT, 32'h0000_0000, r, e);
      n++;
    end
    check("mode", r, {29'h0000_0000, exp});
  endtask : wait_mode

  task complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    logic [31:0] r;
    logic e;
    outs(6'h32); // default primary run
    check("slow osc", SLOW_OSC_EN, 32'h0000_0001); // monitor on
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0008); // flag
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0000); // flags
    wr(pmcs_pkg::OFS_MODE_STAT, 32'h0000_0007);
    rdc("mode ro", pmcs_pkg::OFS_MODE_STAT, 32'h0000_0000); // ro
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    check("unmapped err", e, 32'h0000_0001); // unmapped
    $display("test reset done");
  endtask : t_reset

  task t_primary_idle_state;
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0080);
    pulse(0);
    outs(6'h12); // cpu stopped
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0088); // flag
    pulse(1);
    repeat (WAKE_N - 1) @(negedge SYS_CLK);
    check("cpu held", CPU_CLK_EN, 32'h0000_0000); // ready delay
    wait_mode(3'h0); // resume primary
    outs(6'h32); // cpu running
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0088); // kept
    $display("test primary idle done");
  endtask : t_primary_idle_state

  task t_nop;
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0001);
    pulse(0);
    @(negedge SYS_CLK);
    check("forced nop", FORCED_NOP, 32'h0000_0001); // pulse
    wait_mode(3'h0); // no entry
    $display("test forced nop done");
  endtask : t_nop

  task t_secondary_run_state;
    wr(pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0008);
    pulse(0);
    outs(6'h05); // clocks held
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0001); // flag
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0048); // flag
    @(posedge SYS_CLK);
    SEC_OSC_RUNNING <= 1'b1;
    outs(6'h35); // system on secondary
    pulse(2);
    @(negedge SYS_CLK);
    check("wdt reset", WDT_RESET, 32'h0000_0001); // reset
    wait_mode(3'h1); // no wake
    wr(pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0000);
    @(posedge SYS_CLK);
    outs(6'h37); // keeps secondary
    wait_mode(3'h1); // waits primary
    PRIMARY_READY <= 1'b1;
    wait_mode(3'h0); // switch
    outs(6'h32); // secondary off
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0000);
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0009);
    PRIMARY_READY <= 1'b0;
    $display("test secondary run done");
  endtask : t_secondary_run_state

  task t_secondary_idle_state;
    wr(pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0008);
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0081);
    pulse(0);
    outs(6'h15); // periph secondary
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0048); // flag
    pulse(1);
    wait_mode(3'h1); // secondary run
    outs(6'h37); // cpu on secondary
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0081); // kept
    PRIMARY_READY <= 1'b1;
    wait_mode(3'h0); // switch
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0008); // flag
    PRIMARY_READY <= 1'b0;
    outs(6'h33); // secondary kept
    $display("test secondary idle done");
  endtask : t_secondary_idle_state

  task t_internal_osc_idle_state;
    @(posedge SYS_CLK);
    WDT_ENABLE <= 1'b1;
    FSCM_ENABLE <= 1'b0;
    wr(pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0000);
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0082);
    pulse(0);
    outs(6'h18); // internal mux
    check("fast osc", FAST_OSC_EN, 32'h0000_0000); // kept off
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0082);
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0092);
    @(negedge SYS_CLK);
    check("fast osc", FAST_OSC_EN, 32'h0000_0001); // enabled
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0092);
    repeat (STAB_N + 4) @(posedge SYS_CLK);
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0096);
    check("periph", PERIPH_CLK_EN, 32'h0000_0001); // continues
    pulse(1);
    wait_mode(3'h3); // internal run
    outs(6'h3A); // cpu on mux
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0096);
    PRIMARY_READY <= 1'b1;
    wait_mode(3'h0); // switch
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_009A);
    check("slow osc", SLOW_OSC_EN, 32'h0000_0001); // watchdog on
    PRIMARY_READY <= 1'b0;
    PRIMARY_IS_FAST_INTERNAL_OSCILLATOR <= 1'b1;
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_009E); // fast
    PRIMARY_IS_FAST_INTERNAL_OSCILLATOR <= 1'b0;
    $display("test internal idle done");
  endtask : t_internal_osc_idle_state

  task t_sleep;
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0000);
    pulse(0);
    wait_mode(3'h5); // full sleep
    check("sleep clocks", {CPU_CLK_EN, PERIPH_CLK_EN, PRIMARY_OSC_EN},
      32'h0000_0000);
    pulse(1);
    PRIMARY_READY <= 1'b1;
    wait_mode(3'h0); // back to primary
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0008);
    $display("test sleep done");
  endtask : t_sleep

  task t_reset_instr;
    wr(pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0008);
    wr(pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0001);
    pulse(0);
    wait_mode(3'h1); // secondary run
    pulse(3);
    wait_mode(3'h0); // reset instruction exit
    rdc("sec ctrl", pmcs_pkg::OFS_SEC_CTRL, 32'h0000_0000);
    rdc("osc ctrl", pmcs_pkg::OFS_OSC_CTRL, 32'h0000_0008);
    $display("test reset instruction done");
  endtask : t_reset_instr

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    t_reset();
    t_primary_idle_state();
    t_nop();
    t_secondary_run_state();
    t_secondary_idle_state();
    t_internal_osc_idle_state();
    t_sleep();
    t_reset_instr();
    complete_run();
  end

  initial begin
    repeat (6000) @(posedge SYS_CLK);
    mismatches++;
    complete_run();
  end
endmodule : pmcs_ctrl_tb_top

//--- pmcs_pkg.sv
// pmcs_pkg: constants for the power mode and clock switch controller
// assumes a 125 MHz system clock and an APB register slave
package pmcs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int WAKE_DELAY_US = 10;
  localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int STAB_DELAY_MS = 1;
  localparam int STAB_CYC = STAB_DELAY_MS * 1000 * CLK_MHZ;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEC_CTRL = 8'h04;
  localparam logic [7:0] OFS_MODE_STAT = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_IDLE_SEL = 7;
  localparam int POS_FREQ_LO = 4;
  localparam int POS_PRI_FLAG = 3;
  localparam int POS_FAST_FLAG = 2;
  localparam int POS_CSS_LO = 0;
  localparam int POS_SEC_FLAG = 6;
  localparam int POS_SEC_EN = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_IDLE_SEL = 1'b0;
  localparam logic [2:0] RST_FREQ = 3'h0;
  localparam logic [1:0] RST_CSS = 2'h0;
  localparam logic RST_SEC_EN = 1'b0;
  localparam logic RST_PRI_FLAG = 1'b1;

  // ****************************************
  // clock source codes and modes
  // ****************************************
  localparam logic [1:0] CSS_PRIMARY = 2'h0;
  localparam logic [1:0] CSS_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTMUX = 2'h2;

  typedef enum logic [2:0] {
    primary_run_state = 3'h0,
    secondary_run_state = 3'h1,
    internal_osc_run_state = 3'h3,
    primary_idle_state = 3'h2,
    secondary_idle_state = 3'h6,
    internal_osc_idle_state = 3'h7,
    sleep_state = 3'h5
  } pmcs_mode_t;

endpackage : pmcs_pkg
